// ### design/scrs_pkg.sv
// Constants, register map and state type of the clock and reset sequencer.
// Assumes one oscillator-rate clock; every count is in oscillator cycles.
package scrs_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register bus map and layout.
  localparam int SCRS_ADDR_W = 4;
  localparam int SCRS_DATA_W = 8;
  localparam logic [3:0] SCRS_ADDR_CAUSE = 4'h0;
  localparam logic [3:0] SCRS_ADDR_CTRL = 4'h4;
  localparam logic [3:0] SCRS_ADDR_CNT_LO = 4'h8;
  localparam logic [3:0] SCRS_ADDR_CNT_HI = 4'hC;

  // Reset cause flags.
  localparam int SCRS_CAUSE_POR = 7;
  localparam int SCRS_CAUSE_PIN = 6;
  localparam int SCRS_CAUSE_WDOG = 5;
  localparam int SCRS_CAUSE_ILOP = 4;
  localparam int SCRS_CAUSE_ILAD = 3;
  localparam int SCRS_CAUSE_LVR = 1;
  localparam logic [7:0] SCRS_CAUSE_RESET = 8'h80;

  // Control bits.
  localparam int SCRS_CTRL_PLL_SEL = 0;
  localparam int SCRS_CTRL_SHORT_STOP = 1;
  localparam int SCRS_CTRL_STOP_EN = 2;
  localparam logic [7:0] SCRS_CTRL_RESET = 8'h04;

  ////////////////////////////////////////////////////////////////////////
  // Counts in oscillator cycles.
  localparam int SCRS_CNT_W = 13;
  localparam int SCRS_POR_CYC = 4096;
  localparam int SCRS_STOP_LONG_CYC = 4096;
  localparam int SCRS_STOP_SHORT_CYC = 32;
  localparam int SCRS_PIN_DRIVE_CYC = 32;
  localparam int SCRS_INTERNAL_RESET_TAIL_CYC = 32;
  localparam int SCRS_PIN_FLAG_CYC = 67;
  localparam int SCRS_PIN_FLAG_POR_CYC = 4163;
  localparam int SCRS_SEQ_W = 6;

  localparam logic [12:0] SCRS_POR_LAST = 13'(SCRS_POR_CYC - 1);
  localparam logic [12:0] SCRS_STOP_LONG_LAST = 13'(SCRS_STOP_LONG_CYC - 1);
  localparam logic [12:0] SCRS_STOP_SHORT_LAST =
    13'(SCRS_STOP_SHORT_CYC - 1);
  localparam logic [5:0] SCRS_PIN_DRIVE_LAST = 6'(SCRS_PIN_DRIVE_CYC - 1);
  localparam logic [5:0] SCRS_INTERNAL_RESET_TAIL_LAST = 6'(SCRS_INTERNAL_RESET_TAIL_CYC - 1);

  // Reset vector pairs (high byte address of each pair).
  localparam logic [15:0] SCRS_VEC_USER = 16'hFFFE;
  localparam logic [15:0] SCRS_VEC_MON = 16'hFEFE;

  // Synchroniser reset value: pin idles high at bit 0.
  localparam logic [3:0] SCRS_SYNC_RESET = 4'h1;

  typedef enum logic [2:0] {
    SCRS_RUN,
    SCRS_POR_HOLD,
    SCRS_PIN_DRIVE,
    SCRS_INTERNAL_RESET_TAIL,
    SCRS_EXT_HOLD,
    SCRS_STOP,
    SCRS_STOP_RECOVER,
    SCRS_WAIT
  } scrs_state_t;

endpackage : scrs_pkg

// ### design/scrs_top.sv
// Clock gating and reset sequencer of the system integration unit.
// Assumes CLK_SYS_I is the buffered oscillator clock and that all CPU
// signals are on that clock; pins and detectors are asynchronous.
`timescale 1ns/1ps

// Function
// - Bus runs at a quarter of the selected oscillator or PLL source.
// - Bus clock is the clock generator output halved.
// - After power-on or low voltage, hold clocks and pin low 4096 cycles.
// - On STOP exit the counter runs while CPU and peripheral clocks stay off.
// - STOP exit delay is 4096 or 32 oscillator cycles.
// - WAIT stops CPU clocks but keeps peripheral clocks running.
// - Every reset asserts internal reset and picks user or monitor vector.
// - Internal reset returns registers and modules to defaults.
// - Internal resets clear the counter; pin reset leaves it alone.
// - Each reset source sets its own cause flag.
// - A low reset pin halts all processing.
// - Pin flag needs 67 low cycles; outside must hold pin that long.
// - With power-on or low voltage the pin flag needs 4163 cycles.
// - Internal sources drive the reset pin low for 32 cycles.
// - Internal reset stays asserted 32 cycles after pin drive ends.
// - Illegal address, opcode, watchdog, low voltage, power-on are internal.
// - Power-on or low voltage counts 4096 first, then the normal sequence.
// - Watchdog request is accepted asynchronously.
// - Counter is 13 bits and advances on the falling oscillator edge.
// - Short stop recovery option cuts STOP delay to 32 cycles.
// - STOP clears the counter before the recovery count.
// - Power-on sets the power-on flag and clears all others.
module scrs_top import scrs_pkg::*; #(
  parameter int PIN_FLAG_POR_CYC = SCRS_PIN_FLAG_POR_CYC
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic PLL_CLK_EN_I,
  input wire logic POR_PULSE_I,
  input wire logic LOW_VOLTAGE_I,
  input wire logic WDOG_TIMEOUT_I,
  input wire logic ILLEGAL_OPCODE_I,
  input wire logic ILLEGAL_ADDR_I,
  input wire logic OPCODE_FETCH_I,
  input wire logic STOP_REQ_I,
  input wire logic STOP_EXIT_I,
  input wire logic WAIT_REQ_I,
  input wire logic WAIT_EXIT_I,
  input wire logic MONITOR_MODE_I,
  input wire logic RST_PIN_I,
  input wire logic [3:0] BUS_ADDR_I,
  input wire logic [7:0] BUS_WDATA_I,
  input wire logic BUS_WR_I,
  input wire logic BUS_RD_I,
  output logic [7:0] BUS_RDATA_O,
  output logic RST_PIN_O,
  output logic RST_PIN_OE_O,
  output logic INTERNAL_RESET_O,
  output logic CPU_CLK_EN_O,
  output logic PERIPH_CLK_EN_O,
  output logic CLK_GEN_EN_O,
  output logic [15:0] RESET_VECTOR_O
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations.
  localparam logic [12:0] PIN_POR_LAST = 13'(PIN_FLAG_POR_CYC - 1);
  localparam logic [12:0] PIN_LAST = 13'(SCRS_PIN_FLAG_CYC - 1);

  logic [3:0] sync_meta;
  logic [3:0] sync_q;
  logic porlvi_prev;
  logic pin_low;
  logic por_evt;
  logic lvi_evt;
  logic porlvi_evt;
  logic stop_illegal;
  logic int_evt;
  logic active;
  logic accept_int;
  logic accept_pin;

  scrs_state_t state;
  scrs_state_t next_state;
  logic [5:0] seq;
  logic [5:0] next_seq;
  logic sim_clr;
  logic next_sim_clr;
  logic por_lvi_seen;
  logic next_por_lvi_seen;

  logic [12:0] sim_cnt;
  logic [12:0] next_sim_cnt;
  logic [12:0] pin_cnt;
  logic [12:0] next_pin_cnt;
  logic [12:0] pin_thr;
  logic pin_flag_set;

  logic [1:0] div;
  logic [1:0] next_div;
  logic src_tick;
  logic bus_tick;
  logic clocks_on;

  logic [7:0] cause;
  logic [7:0] next_cause;
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] next_rdata;
  logic next_internal_reset;
  logic next_pin_drive;
  logic next_cpu_en;
  logic next_periph_en;
  logic next_cgen_en;

  // Bus decode shared by the write and read paths.
  function automatic logic addr_is(input logic [3:0] a,
                                   input logic [3:0] ref_a);
    addr_is = (a == ref_a);
  endfunction : addr_is

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every asynchronous source. The second
  // stage is the only reader of the first.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      sync_meta <= SCRS_SYNC_RESET;
      sync_q <= SCRS_SYNC_RESET;
      porlvi_prev <= 1'b0;
    end else begin
      sync_meta <= {POR_PULSE_I, LOW_VOLTAGE_I, WDOG_TIMEOUT_I, RST_PIN_I};
      sync_q <= sync_meta;
      porlvi_prev <= sync_q[3] | sync_q[2];
    end
  end

  // Source decode. Power-on and low voltage act on their rising edge so
  // a long detector pulse does not keep restarting the count.
  always_comb begin
    pin_low = ~sync_q[0];
    por_evt = sync_q[3] & ~porlvi_prev;
    lvi_evt = sync_q[2] & ~porlvi_prev & ~sync_q[3];
    porlvi_evt = por_evt | lvi_evt;
    stop_illegal = STOP_REQ_I & ~ctrl[SCRS_CTRL_STOP_EN];
    int_evt = sync_q[1] | ILLEGAL_OPCODE_I | stop_illegal
      | (ILLEGAL_ADDR_I & OPCODE_FETCH_I);
    active = (state == SCRS_RUN) || (state == SCRS_WAIT)
      || (state == SCRS_STOP) || (state == SCRS_STOP_RECOVER);
    accept_int = active & int_evt & ~porlvi_evt;
    accept_pin = active & ~int_evt & ~porlvi_evt & pin_low;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer. Power-on and low voltage win over every other source and
  // restart the long hold from any state.
  always_comb begin
    next_state = state;
    next_seq = 6'(seq + 6'h01);
    next_sim_clr = 1'b0;
    next_por_lvi_seen = por_lvi_seen;
    if (state == SCRS_RUN && pin_cnt == 13'h0000) begin
      next_por_lvi_seen = 1'b0;
    end
    if (porlvi_evt) begin
      next_state = SCRS_POR_HOLD;
      next_sim_clr = 1'b1;
      next_por_lvi_seen = 1'b1;
    end else if (accept_int) begin
      next_state = SCRS_PIN_DRIVE;
      next_seq = 6'h00;
      next_sim_clr = 1'b1;
      next_por_lvi_seen = 1'b0;
    end else if (accept_pin) begin
      next_state = SCRS_EXT_HOLD;
      next_por_lvi_seen = 1'b0;
    end else begin
      unique case (state)
        SCRS_RUN: begin
          if (STOP_REQ_I) begin
            next_state = SCRS_STOP;
          end else if (WAIT_REQ_I) begin
            next_state = SCRS_WAIT;
          end
        end
        SCRS_WAIT: begin
          if (WAIT_EXIT_I) begin
            next_state = SCRS_RUN;
          end
        end
        SCRS_STOP: begin
          if (STOP_EXIT_I) begin
            next_state = SCRS_STOP_RECOVER;
          end
        end
        SCRS_STOP_RECOVER: begin
          if (sim_cnt == (ctrl[SCRS_CTRL_SHORT_STOP] ? SCRS_STOP_SHORT_LAST
                          : SCRS_STOP_LONG_LAST)) begin
            next_state = SCRS_RUN;
          end
        end
        SCRS_POR_HOLD: begin
          if (!sim_clr && sim_cnt == SCRS_POR_LAST) begin
            next_state = SCRS_PIN_DRIVE;
            next_seq = 6'h00;
          end
        end
        SCRS_PIN_DRIVE: begin
          if (seq == SCRS_PIN_DRIVE_LAST) begin
            next_state = SCRS_INTERNAL_RESET_TAIL;
            next_seq = 6'h00;
          end
        end
        SCRS_INTERNAL_RESET_TAIL: begin
          if (seq == SCRS_INTERNAL_RESET_TAIL_LAST) begin
            next_state = SCRS_RUN;
          end
        end
        SCRS_EXT_HOLD: begin
          if (!pin_low) begin
            next_state = SCRS_INTERNAL_RESET_TAIL;
            next_seq = 6'h00;
          end
        end
      endcase
    end
  end

  // Sequencer registers.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state <= SCRS_POR_HOLD;
      seq <= 6'h00;
      sim_clr <= 1'b1;
      por_lvi_seen <= 1'b1;
    end else begin
      state <= next_state;
      seq <= next_seq;
      sim_clr <= next_sim_clr;
      por_lvi_seen <= next_por_lvi_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Free-running counter on the falling edge. It sits at zero through
  // STOP, so recovery always counts from a clean start.
  always_comb begin
    if (state == SCRS_STOP || sim_clr) begin
      next_sim_cnt = 13'h0000;
    end else begin
      next_sim_cnt = 13'(sim_cnt + 13'h0001);
    end
  end

  // Counter register.
  always_ff @(negedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      sim_cnt <= 13'h0000;
    end else begin
      sim_cnt <= next_sim_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin low-time counter. It saturates at its threshold and sets the flag
  // on every cycle it stays there; the first low cycle counts as zero.
  always_comb begin
    pin_thr = por_lvi_seen ? PIN_POR_LAST : PIN_LAST;
    pin_flag_set = pin_low && (pin_cnt == pin_thr);
    if (!pin_low) begin
      next_pin_cnt = 13'h0000;
    end else if (pin_cnt == pin_thr) begin
      next_pin_cnt = pin_cnt;
    end else begin
      next_pin_cnt = 13'(pin_cnt + 13'h0001);
    end
  end

  // Pin counter register.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pin_cnt <= 13'h0000;
    end else begin
      pin_cnt <= next_pin_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus clock divider: source halved to the generator output, halved
  // again to the bus. It is parked at phase zero while clocks are held.
  always_comb begin
    clocks_on = (state == SCRS_RUN) || (state == SCRS_WAIT);
    src_tick = ctrl[SCRS_CTRL_PLL_SEL] ? PLL_CLK_EN_I : 1'b1;
    bus_tick = clocks_on & src_tick & (div == 2'h3);
    if (!clocks_on) begin
      next_div = 2'h0;
    end else if (src_tick) begin
      next_div = 2'(div + 2'h1);
    end else begin
      next_div = div;
    end
  end

  // Divider register.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      div <= 2'h0;
    end else begin
      div <= next_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cause and control registers. A hardware set beats a software clear
  // in the same cycle; control returns to defaults under internal reset.
  always_comb begin
    next_cause = cause;
    if (BUS_WR_I && addr_is(BUS_ADDR_I, SCRS_ADDR_CAUSE)) begin
      next_cause = cause & ~BUS_WDATA_I;
    end
    if (accept_int) begin
      next_cause[SCRS_CAUSE_WDOG] = next_cause[SCRS_CAUSE_WDOG]
        | sync_q[1];
      next_cause[SCRS_CAUSE_ILOP] = next_cause[SCRS_CAUSE_ILOP]
        | ILLEGAL_OPCODE_I | stop_illegal;
      next_cause[SCRS_CAUSE_ILAD] = next_cause[SCRS_CAUSE_ILAD]
        | (ILLEGAL_ADDR_I & OPCODE_FETCH_I);
    end
    if (lvi_evt) begin
      next_cause[SCRS_CAUSE_LVR] = 1'b1;
    end
    if (pin_flag_set) begin
      next_cause[SCRS_CAUSE_PIN] = 1'b1;
    end
    if (por_evt) begin
      next_cause = SCRS_CAUSE_RESET;
    end
    if (INTERNAL_RESET_O) begin
      next_ctrl = SCRS_CTRL_RESET;
    end else if (BUS_WR_I && addr_is(BUS_ADDR_I, SCRS_ADDR_CTRL)) begin
      next_ctrl = BUS_WDATA_I;
    end else begin
      next_ctrl = ctrl;
    end
  end

  // Read data for the cycle after a read strobe; unmapped reads give 0.
  always_comb begin
    next_rdata = 8'h00;
    if (BUS_RD_I) begin
      if (addr_is(BUS_ADDR_I, SCRS_ADDR_CAUSE)) begin
        next_rdata = cause;
      end else if (addr_is(BUS_ADDR_I, SCRS_ADDR_CTRL)) begin
        next_rdata = ctrl;
      end else if (addr_is(BUS_ADDR_I, SCRS_ADDR_CNT_LO)) begin
        next_rdata = sim_cnt[7:0];
      end else if (addr_is(BUS_ADDR_I, SCRS_ADDR_CNT_HI)) begin
        next_rdata = {3'h0, sim_cnt[12:8]};
      end
    end
  end

  // Register file flops.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      cause <= SCRS_CAUSE_RESET;
      ctrl <= SCRS_CTRL_RESET;
      BUS_RDATA_O <= 8'h00;
    end else begin
      cause <= next_cause;
      ctrl <= next_ctrl;
      BUS_RDATA_O <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs follow the next state so they line up with the sequencer.
  // The pin is driven low only by the open-drain enable.
  always_comb begin
    next_internal_reset = (next_state == SCRS_POR_HOLD)
      || (next_state == SCRS_PIN_DRIVE) || (next_state == SCRS_INTERNAL_RESET_TAIL)
      || (next_state == SCRS_EXT_HOLD);
    next_pin_drive = (next_state == SCRS_POR_HOLD)
      || (next_state == SCRS_PIN_DRIVE);
    next_cpu_en = bus_tick && (state == SCRS_RUN) && !next_internal_reset;
    next_periph_en = bus_tick && !next_internal_reset;
    next_cgen_en = clocks_on & src_tick & div[0];
  end

  // Output flops.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      RST_PIN_O <= 1'b0;
      RST_PIN_OE_O <= 1'b1;
      INTERNAL_RESET_O <= 1'b1;
      CPU_CLK_EN_O <= 1'b0;
      PERIPH_CLK_EN_O <= 1'b0;
      CLK_GEN_EN_O <= 1'b0;
      RESET_VECTOR_O <= SCRS_VEC_USER;
    end else begin
      RST_PIN_O <= 1'b0;
      RST_PIN_OE_O <= next_pin_drive;
      INTERNAL_RESET_O <= next_internal_reset;
      CPU_CLK_EN_O <= next_cpu_en;
      PERIPH_CLK_EN_O <= next_periph_en;
      CLK_GEN_EN_O <= next_cgen_en;
      RESET_VECTOR_O <= MONITOR_MODE_I ? SCRS_VEC_MON
        : SCRS_VEC_USER;
    end
  end

endmodule : scrs_top

// ### tb/scrs_top_asserts.sv
// Port-level checks for the clock and reset sequencer.
// Assumes it is bound to scrs_top and sampled on the oscillator clock.
`timescale 1ns/1ps
module scrs_top_asserts import scrs_pkg::*; #(
  parameter int PIN_FLAG_POR_CYC = SCRS_PIN_FLAG_POR_CYC
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic WDOG_TIMEOUT_I,
  input wire logic MONITOR_MODE_I,
  input wire logic RST_PIN_I,
  input wire logic RST_PIN_OE_O,
  input wire logic INTERNAL_RESET_O,
  input wire logic CPU_CLK_EN_O,
  input wire logic PERIPH_CLK_EN_O,
  input wire logic CLK_GEN_EN_O,
  input wire logic [15:0] RESET_VECTOR_O
);
  logic [12:0] oe_n;
  logic [12:0] next_oe_n;

  // Length of the current pin drive; saturates so a long drive stays legal.
  always_comb begin
    next_oe_n = !RST_PIN_OE_O ? 13'h0 : (&oe_n ? oe_n : oe_n + 13'h1);
  end

  // Register the drive length.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      oe_n <= 13'h0;
    end else begin
      oe_n <= next_oe_n;
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  //////////////////////////////////////////////////////////////////////////
  a_clk_off_rst: assert property (INTERNAL_RESET_O |->
    !CPU_CLK_EN_O && !PERIPH_CLK_EN_O) else $error("clocks run in reset");
  a_oe_in_internal_reset: assert property (RST_PIN_OE_O |-> INTERNAL_RESET_O)
    else $error("pin driven without internal reset");
  a_drive_len: assert property ($fell(RST_PIN_OE_O) |->
    oe_n == 13'h20 || oe_n >= 13'h1020) else $error("bad pin drive length");
  a_internal_reset_tail: assert property ($fell(RST_PIN_OE_O) |->
    INTERNAL_RESET_O [*8] ##24 INTERNAL_RESET_O ##1 !INTERNAL_RESET_O)
    else $error("internal reset tail is not 32 cycles");
  a_cpu_gap: assert property (CPU_CLK_EN_O |=> !CPU_CLK_EN_O [*3])
    else $error("bus enables closer than four cycles");
  a_gen_gap: assert property (CLK_GEN_EN_O |=> !CLK_GEN_EN_O)
    else $error("generator enables back to back");
  a_cpu_per: assert property (CPU_CLK_EN_O |-> PERIPH_CLK_EN_O)
    else $error("cpu enable without peripheral enable");
  a_wdog_acts: assert property ($rose(WDOG_TIMEOUT_I) &&
    !INTERNAL_RESET_O |-> ##[2:4] RST_PIN_OE_O)
    else $error("watchdog request not taken");
  a_pin_halts: assert property ($fell(RST_PIN_I) && !RST_PIN_OE_O &&
    !INTERNAL_RESET_O |-> ##[2:4] INTERNAL_RESET_O && !RST_PIN_OE_O)
    else $error("pin reset not taken or pin driven");
  a_vec_mon: assert property (MONITOR_MODE_I [*2] |->
    RESET_VECTOR_O == SCRS_VEC_MON) else $error("monitor vector missing");
endmodule : scrs_top_asserts

bind scrs_top scrs_top_asserts #(.PIN_FLAG_POR_CYC(PIN_FLAG_POR_CYC)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .WDOG_TIMEOUT_I(WDOG_TIMEOUT_I),
  .MONITOR_MODE_I(MONITOR_MODE_I), .RST_PIN_I(RST_PIN_I),
  .RST_PIN_OE_O(RST_PIN_OE_O), .INTERNAL_RESET_O(INTERNAL_RESET_O),
  .CPU_CLK_EN_O(CPU_CLK_EN_O), .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O),
  .CLK_GEN_EN_O(CLK_GEN_EN_O), .RESET_VECTOR_O(RESET_VECTOR_O));

// ### tb/scrs_far_end.sv
// Far side: the board reset line with its pull-up, an external reset
// switch, and counters standing in for the CPU and peripheral clock users.
// Assumes the device pulls the line only while its enable is high.
`timescale 1ns/1ps
module scrs_far_end (
  input wire logic clk_i,
  input wire logic drive_i,
  input wire logic level_i,
  input wire logic cpu_i,
  input wire logic per_i,
  input wire logic gen_i,
  output logic pin_o
);
  logic ext_low = 1'b0;
  int cpu_n = 0;
  int per_n = 0;
  int gen_n = 0;

  // Wired-low line: either party pulls it down, otherwise the pull-up wins.
  assign pin_o = !((drive_i && !level_i) || ext_low);

  // Count enables as a clocked consumer sees them.
  always @(posedge clk_i) begin
    if (cpu_i === 1'b1) cpu_n <= cpu_n + 1;
    if (per_i === 1'b1) per_n <= per_n + 1;
    if (gen_i === 1'b1) gen_n <= gen_n + 1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Clear the counters between measurement windows.
  task clr();
    cpu_n = 0;
    per_n = 0;
    gen_n = 0;
  endtask : clr

  // External switch: holds the line low for n whole cycles.
  task pull(input int n);
    @(posedge clk_i);
    ext_low <= 1'b1;
    repeat (n) @(posedge clk_i);
    ext_low <= 1'b0;
    @(negedge clk_i);
  endtask : pull
endmodule : scrs_far_end

// ### tb/tb_scrs_top.sv
// Self-checking bench for the clock and reset sequencer.
// Assumes the far-side model resolves the reset line and counts enables.
`timescale 1ns/1ps
module tb_scrs_top;
  import scrs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pll = 1'b0;
  logic mon = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [9:0] ev = 10'h000;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic pin, pin_drv, oe, internal_reset, cpu, per, gen;
  logic [15:0] vec;
  logic [31:0] r, h;
  int n_fail = 0;
  int n_compared = 0;
  int o, t, n, i;
  logic [9:0] src [3] = '{10'h001, 10'h002, 10'h00C};
  logic [31:0] flag [3] = '{32'h20, 32'h10, 32'h08};

  // Oscillator clock and a PLL tick at half its rate.
  always #10 clk = !clk;
  always @(posedge clk) pll <= !pll;

  scrs_top dut (
    .CLK_SYS_I(clk), .RST_I(rst), .PLL_CLK_EN_I(pll), .POR_PULSE_I(ev[8]),
    .LOW_VOLTAGE_I(ev[9]), .WDOG_TIMEOUT_I(ev[0]), .ILLEGAL_OPCODE_I(ev[1]),
    .ILLEGAL_ADDR_I(ev[2]), .OPCODE_FETCH_I(ev[3]), .STOP_REQ_I(ev[4]),
    .STOP_EXIT_I(ev[5]), .WAIT_REQ_I(ev[6]), .WAIT_EXIT_I(ev[7]),
    .MONITOR_MODE_I(mon), .RST_PIN_I(pin), .BUS_ADDR_I(addr),
    .BUS_WDATA_I(wdata), .BUS_WR_I(wr), .BUS_RD_I(rd), .BUS_RDATA_O(rdata),
    .RST_PIN_O(pin_drv), .RST_PIN_OE_O(oe), .INTERNAL_RESET_O(internal_reset),
    .CPU_CLK_EN_O(cpu), .PERIPH_CLK_EN_O(per), .CLK_GEN_EN_O(gen),
    .RESET_VECTOR_O(vec));

  scrs_far_end far (.clk_i(clk), .drive_i(oe), .level_i(pin_drv),
    .cpu_i(cpu), .per_i(per), .gen_i(gen), .pin_o(pin));

  //////////////////////////////////////////////////////////////////////////
  // Compare two values and report a mismatch at once.
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One register access; a read leaves its data in r.
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
    r = {24'h0, rdata};
  endtask : bus

  // One-cycle event on the chosen source lines.
  task fire(input logic [9:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 10'h000;
    @(negedge clk);
  endtask : fire

  // Measure pin drive length and the internal reset that follows it.
  task run_rst(output int od, output int tl);
    od = 0;
    tl = 0;
    for (int k = 0; k < 20 && internal_reset !== 1'b1; k++) @(negedge clk);
    while (oe === 1'b1 && od < 9000) begin
      od++;
      @(negedge clk);
    end
    while (internal_reset === 1'b1 && tl < 9000) begin
      tl++;
      @(negedge clk);
    end
  endtask : run_rst

  // Count enable pulses over a 40-cycle window.
  task rate(input int c, input int p, input int g);
    repeat (8) @(negedge clk);
    far.clr();
    repeat (40) @(negedge clk);
    chk(far.cpu_n, c);
    chk(far.per_n, p);
    chk(far.gen_n, g);
  endtask : rate

  // Cycles until the first CPU enable after a wake-up.
  task wake(output int w);
    w = 0;
    while (cpu !== 1'b1 && w < 5000) begin
      w++;
      @(negedge clk);
    end
  endtask : wake

  // Print the counts and the verdict, then stop.
  task test_done();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  //////////////////////////////////////////////////////////////////////////
  // Main sequence: power-on, clock rates, each reset source, STOP and WAIT.
  initial begin
    repeat (5) @(negedge clk);
    chk({31'h0, internal_reset}, 32'h1);
    @(posedge clk);
    rst <= 1'b0;
    run_rst(o, t);
    chk({31'h0, o >= 4128 && o <= 4136}, 32'h1);
    chk(t, 32);
    chk({16'h0, vec}, 32'hFFFE);
    bus(1'b0, SCRS_ADDR_CAUSE, 8'h00);
    chk(r, 32'h80);
    bus(1'b0, SCRS_ADDR_CTRL, 8'h00);
    chk(r, 32'h04);
    bus(1'b0, 4'h2, 8'h00);
    chk(r, 32'h0);
    rate(10, 10, 20);
    bus(1'b1, SCRS_ADDR_CTRL, 8'h05);
    rate(5, 5, 10);
    bus(1'b1, SCRS_ADDR_CTRL, 8'h04);
    fire(10'h040);
    rate(0, 10, 20);
    fire(10'h080);
    rate(10, 10, 20);
    for (i = 0; i < 3; i++) begin
      bus(1'b1, SCRS_ADDR_CAUSE, 8'hFF);
      fire(src[i]);
      run_rst(o, t);
      chk(o, 32);
      chk(t, 32);
      bus(1'b0, SCRS_ADDR_CAUSE, 8'h00);
      chk(r, flag[i]);
      bus(1'b0, SCRS_ADDR_CNT_HI, 8'h00);
      chk(r, 32'h0);
    end
    fire(10'h004);
    repeat (10) @(negedge clk);
    chk({31'h0, internal_reset}, 32'h0);
    @(posedge clk);
    mon <= 1'b1;
    fire(10'h001);
    run_rst(o, t);
    chk({16'h0, vec}, 32'hFEFE);
    @(posedge clk);
    mon <= 1'b0;
    repeat (600) @(negedge clk);
    bus(1'b0, SCRS_ADDR_CNT_HI, 8'h00);
    h = r;
    bus(1'b1, SCRS_ADDR_CAUSE, 8'hFF);
    far.pull(72);
    run_rst(o, t);
    chk(o, 0);
    bus(1'b0, SCRS_ADDR_CAUSE, 8'h00);
    chk(r, 32'h40);
    bus(1'b0, SCRS_ADDR_CNT_HI, 8'h00);
    chk({31'h0, r >= h && h > 1}, 32'h1);
    bus(1'b1, SCRS_ADDR_CAUSE, 8'hFF);
    far.pull(62);
    run_rst(o, t);
    bus(1'b0, SCRS_ADDR_CAUSE, 8'h00);
    chk(r, 32'h0);
    bus(1'b1, SCRS_ADDR_CTRL, 8'h06);
    fire(10'h010);
    rate(0, 0, 0);
    fire(10'h020);
    wake(n);
    chk({31'h0, n >= 30 && n <= 44}, 32'h1);
    bus(1'b1, SCRS_ADDR_CTRL, 8'h04);
    fire(10'h010);
    fire(10'h020);
    wake(n);
    chk({31'h0, n >= 4094 && n <= 4110}, 32'h1);
    bus(1'b1, SCRS_ADDR_CTRL, 8'h00);
    bus(1'b1, SCRS_ADDR_CAUSE, 8'hFF);
    fire(10'h010);
    run_rst(o, t);
    bus(1'b0, SCRS_ADDR_CAUSE, 8'h00);
    chk(r, 32'h10);
    bus(1'b0, SCRS_ADDR_CTRL, 8'h00);
    chk(r, 32'h04);
    bus(1'b1, SCRS_ADDR_CAUSE, 8'hFF);
    fire(10'h200);
    run_rst(o, t);
    chk({31'h0, o >= 4128 && o <= 4136}, 32'h1);
    bus(1'b0, SCRS_ADDR_CAUSE, 8'h00);
    chk(r, 32'h02);
    fire(10'h100);
    run_rst(o, t);
    bus(1'b0, SCRS_ADDR_CAUSE, 8'h00);
    chk(r, 32'h80);
    test_done();
  end

  // Hang guard: about twice the cycles the sequence needs.
  initial begin
    #(40000 * 20);
    n_fail++;
    test_done();
  end
endmodule : tb_scrs_top
